// ### ppp_defines.vh
`ifndef PPP_DEFINES_VH
`define PPP_DEFINES_VH

// ****************************************************************
// Bus and register map (word index = byte address / 4)
// ****************************************************************
`define PPP_ADDR_W        8
`define PPP_IDX_W         6
`define PPP_IDX_DATA      6'h00
`define PPP_IDX_STATE     6'h01
`define PPP_IDX_CTRL      6'h02
`define PPP_IDX_IRQ_STAT  6'h03
`define PPP_IDX_IRQ_MASK  6'h04
`define PPP_RESP_OKAY     2'h0
`define PPP_RESP_SLVERR   2'h2
`define PPP_PAD24         24'h00_0000

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define PPP_CTL_STROBE    0
`define PPP_CTL_AUTOFEED  1
`define PPP_CTL_CLEAR     2
`define PPP_CTL_SELECT    3
`define PPP_CTL_IRQ_EN    4
`define PPP_CTL_FLOW      5
`define PPP_CTL_RST       8'h00
`define PPP_DATA_RST      8'h00

// ****************************************************************
// State register fixed bits
// ****************************************************************
`define PPP_STATE_RSVD    2'h3

// ****************************************************************
// Event status / mask register
// ****************************************************************
`define PPP_EV_W          2
`define PPP_EV_ACK        0
`define PPP_EV_FAULT      1
`define PPP_EV_RST        2'h0
`define PPP_EV_PAD        6'h00

// ****************************************************************
// Pin synchroniser bit positions
// ****************************************************************
`define PPP_SYNC_W        14
`define PPP_SYNC_RST      14'h3fff
`define PPP_S_PD_HI       7
`define PPP_S_MODE        8
`define PPP_S_FAULT       9
`define PPP_S_SELECT      10
`define PPP_S_MEDIA       11
`define PPP_S_ACK         12
`define PPP_S_BUSY        13

`endif

// ### ppp_sync.v
`timescale 1ns/1ps
`include "ppp_defines.vh"

module ppp_sync #(
  parameter W = `PPP_SYNC_W,
  parameter [W-1:0] RST = `PPP_SYNC_RST
) (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Asynchronous levels in, synchronised levels out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  // ****************************************************************
  // Two-stage synchroniser; only the second stage is visible
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= RST;
      q    <= RST;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // ppp_sync

// ### ppp_top.v
`timescale 1ns/1ps
`include "ppp_defines.vh"

module ppp_top (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [`PPP_ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [`PPP_ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Mode strap pin
  input  wire        enhanced_mode_pin,
  // Printer data lines, split into in / out / enable
  input  wire [7:0]  parallel_data_lines_in,
  output wire [7:0]  parallel_data_lines_out,
  output reg         parallel_data_lines_oe_n,
  // Printer status inputs (pin levels)
  input  wire        fault_status_n,
  input  wire        online_select,
  input  wire        out_of_media,
  input  wire        handshake_return_n,
  input  wire        printer_busy,
  // Printer control outputs, active low on the connector
  output wire        data_strobe_ctl_n,
  output wire        auto_feed_ctl_n,
  output wire        printer_clear_n,
  output wire        select_request_n,
  // Printer interrupt pin, split into value / enable
  output wire        parallel_irq_out,
  output wire        parallel_irq_oe_n,
  // Interrupt to the system
  output wire        irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wire [`PPP_SYNC_W-1:0] pins_raw;
  wire [`PPP_SYNC_W-1:0] pins;
  wire [7:0]             pd_live;
  wire                   mode_ext;
  wire                   flow_in;
  wire                   drive_lines;
  wire                   ack_rise;
  wire                   fault_fall;
  wire [`PPP_EV_W-1:0]   events;
  wire [7:0]             state_val;

  reg  [7:0]             data_latch;
  reg  [7:0]             ctrl;
  reg                    handshake_irq_flag;
  reg                    ack_prev;
  reg                    fault_prev;
  reg  [`PPP_EV_W-1:0]   ev_stat;
  reg  [`PPP_EV_W-1:0]   ev_mask;
  reg  [`PPP_EV_W-1:0]   next_ev_stat;

  reg                    aw_held;
  reg                    w_held;
  reg  [`PPP_IDX_W-1:0]  wr_idx;
  reg  [7:0]             wr_byte;
  reg                    wr_lane0;
  reg  [`PPP_IDX_W-1:0]  rd_idx;
  reg  [7:0]             rd_byte;
  reg                    rd_hit;
  reg                    wr_hit;

  wire                   wr_go;
  wire                   rd_go;
  wire                   wr_ok;
  wire                   rd_state;
  wire                   rd_evstat;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  assign pins_raw = {printer_busy, handshake_return_n, out_of_media,
                     online_select, fault_status_n, enhanced_mode_pin,
                     parallel_data_lines_in};

  ppp_sync #(
    .W   (`PPP_SYNC_W),
    .RST (`PPP_SYNC_RST)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pins_raw),
    .q       (pins)
  );

  assign pd_live  = pins[`PPP_S_PD_HI:0];
  assign mode_ext = pins[`PPP_S_MODE];
  assign flow_in  = ctrl[`PPP_CTL_FLOW];

  // Drivers off only in extended mode with flow set
  assign drive_lines = ~mode_ext | ~flow_in;

  // ****************************************************************
  // Data lines
  // ****************************************************************
  // Latch drives the lines whenever enabled; writes land immediately
  assign parallel_data_lines_out = data_latch;

  // Registered to keep the enable glitch-free at the pad
  always @(posedge aclk)
  begin
    if (!aresetn)
      parallel_data_lines_oe_n <= 1'b0;
    else
      parallel_data_lines_oe_n <= ~drive_lines;
  end

  // ****************************************************************
  // Control lines toward the printer
  // ****************************************************************
  assign data_strobe_ctl_n = ~ctrl[`PPP_CTL_STROBE];
  assign auto_feed_ctl_n   = ~ctrl[`PPP_CTL_AUTOFEED];
  assign printer_clear_n   = ctrl[`PPP_CTL_CLEAR];
  assign select_request_n  = ~ctrl[`PPP_CTL_SELECT];

  // Pin is high while the flag is cleared; floats when disabled
  assign parallel_irq_out  = ~handshake_irq_flag;
  assign parallel_irq_oe_n = ~ctrl[`PPP_CTL_IRQ_EN];

  // ****************************************************************
  // Handshake edge detection and interrupt flag
  // ****************************************************************
  // Release of the active-low handshake is a rising pin level
  assign ack_rise   = pins[`PPP_S_ACK] & ~ack_prev;
  assign fault_fall = ~pins[`PPP_S_FAULT] & fault_prev;
  assign events     = {fault_fall, ack_rise};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_prev   <= 1'b1;
      fault_prev <= 1'b1;
    end
    else
    begin
      ack_prev   <= pins[`PPP_S_ACK];
      fault_prev <= pins[`PPP_S_FAULT];
    end
  end

  // A release in the same cycle as a state read wins, so none is lost
  always @(posedge aclk)
  begin
    if (!aresetn)
      handshake_irq_flag <= 1'b1;
    else if (ack_rise)
      handshake_irq_flag <= 1'b0;
    else if (rd_state)
      handshake_irq_flag <= 1'b1;
  end

  // Straight pin levels in bits 7:3, busy inverted; the latched handshake flag in bit 2, fixed ones in bits 1:0
  assign state_val = {~pins[`PPP_S_BUSY],
                      pins[`PPP_S_ACK],
                      pins[`PPP_S_MEDIA],
                      pins[`PPP_S_SELECT],
                      pins[`PPP_S_FAULT],
                      handshake_irq_flag,
                      `PPP_STATE_RSVD};

  // ****************************************************************
  // Sticky event status, read-to-clear, set wins
  // ****************************************************************
  always @*
  begin
    next_ev_stat = ev_stat;
    if (rd_evstat)
      next_ev_stat = {`PPP_EV_W{1'b0}};
    next_ev_stat = next_ev_stat | events;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      ev_stat <= `PPP_EV_RST;
    else
      ev_stat <= next_ev_stat;
  end

  assign irq = |(ev_stat & ev_mask);

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_go         = aw_held & w_held & ~s_axi_bvalid;

  always @*
  begin
    case (wr_idx)
      `PPP_IDX_DATA, `PPP_IDX_STATE, `PPP_IDX_CTRL,
      `PPP_IDX_IRQ_STAT, `PPP_IDX_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Only byte lane 0 carries register data
  assign wr_ok = wr_go & wr_hit & wr_lane0;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_idx       <= {`PPP_IDX_W{1'b0}};
      wr_byte      <= 8'h00;
      wr_lane0     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PPP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        wr_idx  <= s_axi_awaddr[`PPP_ADDR_W-1:2];
      end
      else if (wr_go)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held   <= 1'b1;
        wr_byte  <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      else if (wr_go)
        w_held <= 1'b0;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PPP_RESP_OKAY : `PPP_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  // State and event status ignore writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_latch <= `PPP_DATA_RST;
      ctrl       <= `PPP_CTL_RST;
      ev_mask    <= `PPP_EV_RST;
    end
    else if (wr_ok)
    begin
      case (wr_idx)
        `PPP_IDX_DATA:     data_latch <= wr_byte;
        `PPP_IDX_CTRL:     ctrl       <= wr_byte;
        `PPP_IDX_IRQ_MASK: ev_mask    <= wr_byte[`PPP_EV_W-1:0];
        default:           ctrl       <= ctrl;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go         = s_axi_arvalid & s_axi_arready;
  assign rd_state      = rd_go & (rd_idx == `PPP_IDX_STATE);
  assign rd_evstat     = rd_go & (rd_idx == `PPP_IDX_IRQ_STAT);

  always @*
  begin
    rd_idx  = s_axi_araddr[`PPP_ADDR_W-1:2];
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      `PPP_IDX_DATA:
      begin
        // Live lines only when extended mode has released them
        if (mode_ext && flow_in)
          rd_byte = pd_live;
        else
          rd_byte = data_latch;
      end
      `PPP_IDX_STATE:    rd_byte = state_val;
      `PPP_IDX_CTRL:     rd_byte = ctrl;
      `PPP_IDX_IRQ_STAT: rd_byte = {`PPP_EV_PAD, ev_stat};
      `PPP_IDX_IRQ_MASK: rd_byte = {`PPP_EV_PAD, ev_mask};
      default:           rd_hit  = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PPP_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {`PPP_PAD24, rd_byte};
      s_axi_rresp  <= rd_hit ? `PPP_RESP_OKAY : `PPP_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // ppp_top

// ### ppp_printer.sv
`timescale 1ns/1ps
// ****************************************
// Printer on the far side of the port
// ****************************************
module ppp_printer (
  // Clock
  input  logic       aclk,
  // From the port
  input  logic       data_strobe_ctl_n,
  input  logic       parallel_data_lines_oe_n,
  input  logic [7:0] parallel_data_lines_out,
  // To the port
  output logic [7:0] parallel_data_lines_in,
  output logic       fault_status_n,
  output logic       online_select,
  output logic       out_of_media,
  output logic       handshake_return_n,
  output logic       printer_busy
);
  // Strobe-to-acknowledge delay; raise it to model a slow printer
  int         wait_cyc = 3;
  int         cnt = 0;
  logic [7:0] own_data = 8'h3c;
  initial {fault_status_n, online_select, out_of_media} = 3'h6;
  // The printer only drives the data lines once the port lets go of them
  assign parallel_data_lines_in = parallel_data_lines_oe_n ? own_data : parallel_data_lines_out;
  always @(posedge aclk) cnt <= data_strobe_ctl_n ? 0 : (cnt < wait_cyc + 9 ? cnt + 1 : cnt);
  assign printer_busy = !data_strobe_ctl_n && cnt < wait_cyc;
  assign handshake_return_n = !(!data_strobe_ctl_n && cnt >= wait_cyc && cnt < wait_cyc + 3);
endmodule // ppp_printer

// ### ppp_top_props.sv
`timescale 1ns/1ps
`include "ppp_defines.vh"
// ****************************************
// Port checker
// ****************************************
module ppp_top_props (
  // Clock, reset and bus
  input logic        aclk,
  input logic        aresetn,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  // Printer side
  input logic        enhanced_mode_pin,
  input logic        parallel_data_lines_oe_n,
  input logic        fault_status_n,
  input logic        online_select,
  input logic        out_of_media,
  input logic        handshake_return_n,
  input logic        printer_busy,
  input logic        data_strobe_ctl_n,
  input logic        auto_feed_ctl_n,
  input logic        printer_clear_n,
  input logic        select_request_n,
  input logic        parallel_irq_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pins reach the state register through a two-stage synchroniser
  logic [4:0] pins;
  assign pins = {~printer_busy, handshake_return_n, out_of_media, online_select, fault_status_n};
  sequence ar_at(logic [5:0] i);
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == i;
  endsequence
  sequence ext_held;
    enhanced_mode_pin [*4];
  endsequence
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid not held");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid not held");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  state_fixed_a: assert property (ar_at(6'h01) |=> s_axi_rdata[1:0] == `PPP_STATE_RSVD)
    else $error("state bits 1:0 not set");
  state_pins_a: assert property (ar_at(6'h01) |=> s_axi_rdata[7:3] == $past(pins, 3))
    else $error("state pins wrong");
  ctl_lines_a: assert property (ar_at(6'h02) |=> (~s_axi_rdata[4:0] ^ 5'h04) ==
    {parallel_irq_oe_n, select_request_n, printer_clear_n, auto_feed_ctl_n, data_strobe_ctl_n})
    else $error("control lines wrong");
  mode_drive_a: assert property (!enhanced_mode_pin [*4] |-> !parallel_data_lines_oe_n)
    else $error("lines not driven");
  flow_float_a: assert property (ext_held ##0 ar_at(6'h02) |=> s_axi_rdata[5] == parallel_data_lines_oe_n)
    else $error("direction wrong");
endmodule // ppp_top_props
bind ppp_top ppp_top_props chk (.*);

// ### ppp_top_bench.sv
`timescale 1ns/1ps
`include "ppp_defines.vh"
// ****************************************
// Bench
// ****************************************
module ppp_top_bench;
  logic        aclk = 1'b0, aresetn = 1'b0, enhanced_mode_pin = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  parallel_data_lines_in, parallel_data_lines_out;
  logic        parallel_data_lines_oe_n, fault_status_n, online_select, out_of_media;
  logic        handshake_return_n, printer_busy, data_strobe_ctl_n, auto_feed_ctl_n;
  logic        printer_clear_n, select_request_n, parallel_irq_out, parallel_irq_oe_n, irq;
  int          fail_count = 0, num_checks = 0;
  always #2.5 aclk = ~aclk;
  ppp_top dut (.*);
  ppp_printer prn (.*);
  task close_out;
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task axw(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {`PPP_PAD24, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    axr(a);
    chk(d[7:0], exp);
  endtask
  task t_reset;
    rd(8'h08, 8'h00);
    chk({4'h0, printer_clear_n, data_strobe_ctl_n, auto_feed_ctl_n, select_request_n}, 8'h07);
    rd(8'h04, 8'hdf);
    prn.online_select <= 1'b0;
    prn.out_of_media <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(8'h04, 8'hef);
    prn.online_select <= 1'b1;
    prn.out_of_media <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task t_ack;
    prn.wait_cyc = 12;
    axw(8'h10, 8'h00);
    axw(8'h08, 8'h11);
    repeat (4) @(posedge aclk);
    rd(8'h04, 8'h5f);
    for (int n = 0; n < 60 && parallel_irq_out !== 1'b1; n++) @(posedge aclk);
    chk({6'h00, parallel_irq_out, irq}, 8'h02);
    repeat (4) @(posedge aclk);
    rd(8'h04, 8'hdb);
    rd(8'h04, 8'hdf);
    axw(8'h10, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rd(8'h0c, 8'h01);
    chk({7'h00, irq}, 8'h00);
    // A fault edge is logged but stays masked off the interrupt
    prn.fault_status_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({7'h00, irq}, 8'h00);
    rd(8'h04, 8'hd7);
    rd(8'h0c, 8'h02);
    prn.fault_status_n <= 1'b1;
    axw(8'h08, 8'h00);
  endtask
  task t_ctrl;
    for (int i = 0; i < 5; i++)
    begin
      axw(8'h08, 8'h01 << i);
      rd(8'h08, 8'h01 << i);
      chk({3'h0, parallel_irq_oe_n, select_request_n, printer_clear_n, auto_feed_ctl_n, data_strobe_ctl_n},
          {3'h0, ~(5'h01 << i) ^ 5'h04});
    end
  endtask
  task t_modes;
    axw(8'h08, 8'h20);
    axw(8'h00, 8'ha5);
    chk(parallel_data_lines_out, 8'ha5);
    repeat (4) @(posedge aclk);
    chk({7'h00, parallel_data_lines_oe_n}, 8'h00);
    rd(8'h00, 8'ha5);
    enhanced_mode_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({7'h00, parallel_data_lines_oe_n}, 8'h01);
    rd(8'h08, 8'h20);
    rd(8'h00, 8'h3c);
    axw(8'h00, 8'h96);
    chk(parallel_data_lines_out, 8'h96);
    axw(8'h08, 8'h00);
    @(posedge aclk);
    chk({7'h00, parallel_data_lines_oe_n}, 8'h00);
    rd(8'h00, 8'h96);
  endtask
  task t_ro;
    axr(8'h04);
    axw(8'h04, 8'h00);
    chk({6'h00, r}, {6'h00, `PPP_RESP_OKAY});
    rd(8'h04, 8'hdf);
    axr(8'h40);
    chk({r, d[5:0]}, {`PPP_RESP_SLVERR, 6'h00});
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset;
    t_ack;
    t_ctrl;
    t_modes;
    t_ro;
    close_out;
  end
  // A hang counts as a mismatch
  initial
  begin
    #200000;
    fail_count++;
    close_out;
  end
endmodule // ppp_top_bench
